/* src/smoke_pkg.sv */
// Notes on behaviour
// RULE1 - discharge interconnect one second after local alarm
// RULE2 - filtered remote high enters remote alarm, horn
// RULE3 - interconnect input filtered for 500 ms
// RULE4 - latch battery result at LED pulse end
// RULE5 - low battery chirps 7.9 ms every 32 s
// RULE6 - chamber test every 32 s, high gain
// RULE7 - two chamber fails give 32 s chirps
// RULE8 - battery chirp after LED, chamber 16.2 s later
// RULE9 - no battery or chamber checks in alarm
// RULE10 - diagnostic entry after one held oscillator clock
// RULE11 - diagnostic: bias on, emitter every clock
// RULE12 - diagnostic: interconnect input only, routes amplifier
// RULE13 - diagnostic: reference picks gain and output pin
// RULE14 - diagnostic: feedback high enables gain hysteresis
// RULE15 - diagnostic: external clock on oscillator pin
// RULE16 - diagnostic: horn electrode shows integrator result
// RULE17 - diagnostic: LED shows low battery comparator
// RULE18 - no smoke sample while horn sounds
// RULE19 - local horn cycle completes; remote stops
// RULE20 - battery chirp suppressed in any alarm
// RULE21 - discharge only after local, never remote
// RULE22 - three smoke detections enter local alarm
// RULE23 - local alarm drives interconnect, ignores input
// RULE24 - standby LED pulse 7.9 ms every 32 s
// RULE25 - filtered input low leaves remote alarm
package smoke_pkg;

   // ==========================================================
   // time base
   localparam int unsigned CLK_MHZ = 10;
   localparam int unsigned T_OSC_US = 7900;
   localparam int unsigned T_DIAG_OSC_US = 10500;
   localparam int unsigned T_PERIOD_US = 32000000;
   localparam int unsigned T_SAMPLE_US = 8100000;
   localparam int unsigned T_FAST_US = 250000;
   localparam int unsigned T_CHAMBER_OFS_US = 16200000;
   localparam int unsigned T_FILTER_US = 500000;
   localparam int unsigned T_DUMP_US = 1000000;
   localparam int unsigned T_HORN_ON_US = 500000;
   localparam int unsigned T_HORN_PERIOD_US = 1000000;
   localparam int unsigned T_LED_ALARM_US = 500000;
   localparam int unsigned T_EMIT_US = 100;

   localparam int unsigned OSC_CYC = T_OSC_US * CLK_MHZ;
   localparam int unsigned DIAG_OSC_CYC = T_DIAG_OSC_US * CLK_MHZ;
   localparam int unsigned PERIOD_CYC = T_PERIOD_US * CLK_MHZ;
   localparam int unsigned SAMPLE_CYC = T_SAMPLE_US * CLK_MHZ;
   localparam int unsigned FAST_CYC = T_FAST_US * CLK_MHZ;
   localparam int unsigned CHAMBER_OFS_CYC = T_CHAMBER_OFS_US * CLK_MHZ;
   localparam int unsigned FILTER_CYC = T_FILTER_US * CLK_MHZ;
   localparam int unsigned DUMP_CYC = T_DUMP_US * CLK_MHZ;
   localparam int unsigned HORN_ON_CYC = T_HORN_ON_US * CLK_MHZ;
   localparam int unsigned HORN_PERIOD_CYC = T_HORN_PERIOD_US * CLK_MHZ;
   localparam int unsigned LED_ALARM_CYC = T_LED_ALARM_US * CLK_MHZ;
   localparam logic [31:0] EMIT_CYC = 32'(T_EMIT_US * CLK_MHZ);

   // ==========================================================
   // detection counts
   localparam logic [1:0] SMOKE_HITS = 2'h3;
   localparam logic [1:0] CLEAR_HITS = 2'h3;
   localparam logic [1:0] CHAMBER_FAILS = 2'h2;

   // ==========================================================
   // register map
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam int CTRL_DIAG_EXIT_BIT = 0;
   localparam int CTRL_EXT_CLK_BIT = 1;
   localparam logic CTRL_EXT_CLK_RESET = 1'b0;
   localparam int STAT_MODE_LSB = 0;
   localparam int STAT_LOW_BATT_BIT = 4;
   localparam int STAT_CHAMBER_BIT = 5;
   localparam int STAT_REMOTE_BIT = 6;
   localparam int STAT_DUMP_BIT = 7;
   localparam int STAT_HORN_BIT = 8;

   // ==========================================================
   // operating modes
   typedef enum logic [3:0] {
      ST_STANDBY = 4'b0001,
      ST_LOCAL = 4'b0010,
      ST_REMOTE = 4'b0100,
      ST_DIAG = 4'b1000
   } mode_t;

endpackage

/* src/io_link_if.sv */
`timescale 1ns/1ns
// core side drives the pin level and alarm state, link side answers
interface io_link_if;
   logic io_level;
   logic local_alarm;
   logic ignore_input;
   logic remote_level;
   logic discharge_on;
   modport core (output io_level, output local_alarm,
                 output ignore_input, input remote_level,
                 input discharge_on);
   modport link (input io_level, input local_alarm,
                 input ignore_input, output remote_level,
                 output discharge_on);
endinterface

/* src/io_link.sv */
`timescale 1ns/1ns
module io_link
   import smoke_pkg::*;
#(
   parameter int unsigned FILT_CYC = FILTER_CYC,
   parameter int unsigned DISCH_CYC = DUMP_CYC
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // core side
   io_link_if.link lnk
);

   logic [31:0] filt_cnt;
   logic [31:0] dump_cnt;
   logic local_prev;
   logic remote_q;

   // ==========================================================
   // level must hold a full filter time before it counts
   // pulsed co-alarm signals never stay long enough to pass
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         filt_cnt <= 32'h0;
         remote_q <= 1'b0;
      end else if (lnk.ignore_input) begin
         filt_cnt <= 32'h0; // RULE23
         remote_q <= 1'b0;
      end else if (lnk.io_level == remote_q) begin
         filt_cnt <= 32'h0;
      end else if (filt_cnt == FILT_CYC - 1) begin
         filt_cnt <= 32'h0; // RULE3
         remote_q <= lnk.io_level;
      end else begin
         filt_cnt <= filt_cnt + 32'h1;
      end
   end

   // ==========================================================
   // pull-down armed only by the end of a local alarm
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         local_prev <= 1'b0;
         dump_cnt <= 32'h0;
      end else begin
         local_prev <= lnk.local_alarm;
         if (local_prev && !lnk.local_alarm) begin
            dump_cnt <= DISCH_CYC; // RULE1 RULE21
         end else if (lnk.local_alarm) begin
            dump_cnt <= 32'h0;
         end else if (dump_cnt != 32'h0) begin
            dump_cnt <= dump_cnt - 32'h1;
         end
      end
   end

   assign lnk.remote_level = remote_q;
   assign lnk.discharge_on = (dump_cnt != 32'h0);

endmodule

/* src/smoke_ctrl.sv */
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ns
module smoke_ctrl
   import smoke_pkg::*;
#(
   parameter int unsigned P_OSC_CYC = OSC_CYC,
   parameter int unsigned P_DIAG_OSC_CYC = DIAG_OSC_CYC,
   parameter int unsigned P_PERIOD_CYC = PERIOD_CYC,
   parameter int unsigned P_SAMPLE_CYC = SAMPLE_CYC,
   parameter int unsigned P_FAST_CYC = FAST_CYC,
   parameter int unsigned P_CHAMBER_OFS_CYC = CHAMBER_OFS_CYC,
   parameter int unsigned P_FILTER_CYC = FILTER_CYC,
   parameter int unsigned P_DUMP_CYC = DUMP_CYC,
   parameter int unsigned P_HORN_ON_CYC = HORN_ON_CYC,
   parameter int unsigned P_HORN_PERIOD_CYC = HORN_PERIOD_CYC,
   parameter int unsigned P_LED_ALARM_CYC = LED_ALARM_CYC
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // analog front end results
   input wire logic smoke_detected,
   input wire logic low_batt_compare,
   input wire logic chamber_fail_compare,
   input wire logic test_diag_entry,
   input wire logic battery_threshold_ref,
   input wire logic feed_in,
   input wire logic osc_capacitor_pin,
   // interconnect pin
   input wire logic io_in,
   output logic io_out,
   output logic io_oe,
   output logic io_discharge,
   // horn, indicator and front end controls
   output logic horn_metal_drive,
   output logic led_on,
   output logic emitter_drive,
   output logic amp_bias_on,
   output logic high_gain_sel,
   output logic hysteresis_en,
   output logic amp_to_high_gain_cap_pin,
   output logic amp_to_normal_gain_cap_pin
);

   // window test used for the chirp, chamber test and chamber emitter slots of the timing cycles
   function automatic logic in_window(input logic [31:0] cnt,
                                      input logic [31:0] start,
                                      input logic [31:0] len);
      in_window = (cnt >= start) && (cnt < start + len);
   endfunction

   io_link_if lnk ();

   mode_t mode;
   mode_t next_mode;
   logic [31:0] phase_cnt;
   logic [31:0] smp_cnt;
   logic [31:0] smp_limit;
   logic [31:0] horn_cnt;
   logic [31:0] hold_cnt;
   logic [31:0] dtick_cnt;
   logic [31:0] emit_cnt;
   logic [31:0] phase_limit;
   logic [31:0] status_word;
   logic [1:0] smoke_hits;
   logic [1:0] clear_hits;
   logic [1:0] chamber_fails;
   logic low_batt;
   logic chamber_fault;
   logic horn_run;
   logic ext_clk_sel;
   logic diag_exit;
   logic osc_prev;
   logic standby;
   logic local_m;
   logic diag;
   logic alarm_horn;
   logic lb_chirp;
   logic ch_chirp;
   logic horn_on;
   logic smp_window;
   logic smp_take;
   logic chamber_win;
   logic chamber_end;
   logic lb_end;
   logic diag_enter;
   logic diag_tick;
   logic diag_emit;
   logic norm_emit;
   logic apb_setup;
   logic apb_access;
   logic addr_ok;

   // ==========================================================
   // interconnect filter and discharge
   io_link #(
      .FILT_CYC(P_FILTER_CYC),
      .DISCH_CYC(P_DUMP_CYC)
   ) u_io_link (
      .pclk(pclk),
      .presetn(presetn),
      .lnk(lnk)
   );

   assign lnk.io_level = io_in;
   assign lnk.local_alarm = local_m;
   // own drive and test modes must not feed back as remote alarm
   assign lnk.ignore_input = local_m || diag; // RULE23 RULE12

   // ==========================================================
   // decoded timing slots
   assign standby = (mode == ST_STANDBY);
   assign local_m = (mode == ST_LOCAL);
   assign diag = (mode == ST_DIAG);
   assign alarm_horn = horn_run && (horn_cnt < P_HORN_ON_CYC);
   // chirps live only in standby, so alarms silence them
   assign lb_chirp = standby && low_batt &&
      in_window(phase_cnt, P_OSC_CYC, P_OSC_CYC); // RULE5 RULE8 RULE20
   assign ch_chirp = standby && chamber_fault &&
      in_window(phase_cnt, P_OSC_CYC + P_CHAMBER_OFS_CYC,
                P_OSC_CYC); // RULE7 RULE8
   assign horn_on = alarm_horn || lb_chirp || ch_chirp;
   assign smp_window = (standby || local_m) && (smp_cnt < P_OSC_CYC);
   // a sample overlapped by the horn is thrown away
   assign smp_take = smp_window && (smp_cnt == P_OSC_CYC - 1) &&
      !horn_on; // RULE18
   assign smp_limit = (smoke_hits != 2'h0 || local_m) ?
      P_FAST_CYC : P_SAMPLE_CYC;
   assign lb_end = standby && (phase_cnt == P_OSC_CYC - 1); // RULE4
   assign chamber_win = standby &&
      in_window(phase_cnt, 2 * P_OSC_CYC, P_OSC_CYC); // RULE6 RULE9
   assign chamber_end = standby && (phase_cnt == 3 * P_OSC_CYC - 1);
   assign phase_limit = local_m ? P_LED_ALARM_CYC : P_PERIOD_CYC;
   assign diag_enter = test_diag_entry &&
      (hold_cnt == P_OSC_CYC - 1); // RULE10
   assign diag_tick = diag && (ext_clk_sel ?
      (osc_capacitor_pin && !osc_prev) :
      (dtick_cnt == P_DIAG_OSC_CYC - 1)); // RULE15 RULE11
   assign diag_emit = (emit_cnt != 32'h0);
   assign norm_emit = (smp_window && !horn_on &&
      smp_cnt >= P_OSC_CYC - EMIT_CYC) ||
      (standby && in_window(phase_cnt, 3 * P_OSC_CYC - EMIT_CYC,
                            EMIT_CYC));

   // ==========================================================
   // mode selection
   always_comb begin
      next_mode = mode;
      case (mode)
         ST_STANDBY: begin
            if (diag_enter) begin
               next_mode = ST_DIAG;
            end else if (smp_take && smoke_detected &&
                         smoke_hits == SMOKE_HITS - 2'h1) begin
               next_mode = ST_LOCAL; // RULE22
            end else if (lnk.remote_level) begin
               next_mode = ST_REMOTE; // RULE2
            end
         end
         ST_REMOTE: begin
            if (diag_enter) begin
               next_mode = ST_DIAG;
            end else if (!lnk.remote_level) begin
               next_mode = ST_STANDBY; // RULE25
            end
         end
         ST_LOCAL: begin
            if (diag_enter) begin
               next_mode = ST_DIAG;
            end else if (smp_take && !smoke_detected &&
                         clear_hits == CLEAR_HITS - 2'h1) begin
               next_mode = ST_STANDBY;
            end
         end
         ST_DIAG: begin
            if (diag_exit) begin
               next_mode = ST_STANDBY;
            end
         end
         default: begin
            next_mode = ST_STANDBY;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode <= ST_STANDBY;
      end else begin
         mode <= next_mode;
      end
   end

   // ==========================================================
   // 32 s cycle in standby, LED cycle in local alarm
   // restarts on every mode change so standby timing resumes clean
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_cnt <= 32'h0;
      end else if (next_mode != mode || !(standby || local_m)) begin
         phase_cnt <= 32'h0; // RULE25
      end else if (phase_cnt == phase_limit - 1) begin
         phase_cnt <= 32'h0;
      end else begin
         phase_cnt <= phase_cnt + 32'h1;
      end
   end

   // ==========================================================
   // smoke sampling interval, held at its start while horn sounds
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         smp_cnt <= 32'h0;
      end else if (!(standby || local_m)) begin
         smp_cnt <= 32'h0;
      end else if (smp_cnt == 32'h0 && horn_on) begin
         smp_cnt <= 32'h0; // RULE18
      end else if (smp_cnt >= smp_limit - 1) begin
         smp_cnt <= 32'h0;
      end else begin
         smp_cnt <= smp_cnt + 32'h1;
      end
   end

   // consecutive smoke and clear counts
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         smoke_hits <= 2'h0;
         clear_hits <= 2'h0;
      end else if (next_mode != mode) begin
         smoke_hits <= 2'h0;
         clear_hits <= 2'h0;
      end else if (smp_take && standby) begin
         smoke_hits <= smoke_detected ? smoke_hits + 2'h1 : 2'h0;
      end else if (smp_take && local_m) begin
         clear_hits <= smoke_detected ? 2'h0 : clear_hits + 2'h1;
      end
   end

   // ==========================================================
   // horn cycle in alarm
   // local finishes the running burst, remote cuts it at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         horn_run <= 1'b0;
         horn_cnt <= 32'h0;
      end else if (mode == ST_REMOTE && next_mode != ST_REMOTE) begin
         horn_run <= 1'b0; // RULE19
         horn_cnt <= 32'h0;
      end else if (local_m || mode == ST_REMOTE) begin
         horn_run <= 1'b1; // RULE2 RULE22
         if (horn_cnt == P_HORN_PERIOD_CYC - 1) begin
            horn_cnt <= 32'h0;
         end else begin
            horn_cnt <= horn_cnt + 32'h1;
         end
      end else if (horn_run) begin
         if (horn_cnt >= P_HORN_ON_CYC - 1) begin
            horn_run <= 1'b0; // RULE19
            horn_cnt <= 32'h0;
         end else begin
            horn_cnt <= horn_cnt + 32'h1;
         end
      end
   end

   // ==========================================================
   // battery latch and chamber fault tracking, standby only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_batt <= 1'b0;
      end else if (lb_end) begin
         low_batt <= low_batt_compare; // RULE4 RULE5 RULE9
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chamber_fails <= 2'h0;
         chamber_fault <= 1'b0;
      end else if (chamber_end && chamber_fail_compare) begin
         if (chamber_fails != CHAMBER_FAILS) begin
            chamber_fails <= chamber_fails + 2'h1;
         end
         if (chamber_fails >= CHAMBER_FAILS - 2'h1) begin
            chamber_fault <= 1'b1; // RULE7
         end
      end else if (chamber_end) begin
         chamber_fails <= 2'h0;
         chamber_fault <= 1'b0;
      end
   end

   // ==========================================================
   // diagnostic entry hold and diagnostic emitter clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_cnt <= 32'h0;
         dtick_cnt <= 32'h0;
         emit_cnt <= 32'h0;
         osc_prev <= 1'b0;
      end else begin
         osc_prev <= osc_capacitor_pin;
         if (!test_diag_entry || diag || diag_enter) begin
            hold_cnt <= 32'h0;
         end else begin
            hold_cnt <= hold_cnt + 32'h1; // RULE10
         end
         if (!diag || dtick_cnt == P_DIAG_OSC_CYC - 1) begin
            dtick_cnt <= 32'h0;
         end else begin
            dtick_cnt <= dtick_cnt + 32'h1;
         end
         if (diag_tick) begin
            emit_cnt <= EMIT_CYC; // RULE11
         end else if (!diag) begin
            emit_cnt <= 32'h0;
         end else if (emit_cnt != 32'h0) begin
            emit_cnt <= emit_cnt - 32'h1;
         end
      end
   end

   // ==========================================================
   // pin outputs, all from flip-flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         io_out <= 1'b0;
         io_oe <= 1'b0;
         io_discharge <= 1'b0;
         horn_metal_drive <= 1'b0;
         led_on <= 1'b0;
         emitter_drive <= 1'b0;
         amp_bias_on <= 1'b0;
         high_gain_sel <= 1'b0;
         hysteresis_en <= 1'b0;
         amp_to_high_gain_cap_pin <= 1'b0;
         amp_to_normal_gain_cap_pin <= 1'b0;
      end else if (diag) begin
         io_out <= 1'b0; // RULE12
         io_oe <= 1'b0;
         io_discharge <= 1'b0;
         horn_metal_drive <= smoke_detected; // RULE16
         led_on <= low_batt_compare; // RULE17
         emitter_drive <= diag_emit; // RULE11
         amp_bias_on <= 1'b1; // RULE11
         high_gain_sel <= io_in && battery_threshold_ref; // RULE13
         hysteresis_en <= !battery_threshold_ref && feed_in; // RULE14
         amp_to_high_gain_cap_pin <= io_in && !battery_threshold_ref &&
            diag_emit; // RULE12 RULE13
         amp_to_normal_gain_cap_pin <= io_in && battery_threshold_ref &&
            diag_emit; // RULE12 RULE13
      end else begin
         io_out <= local_m; // RULE23
         io_oe <= local_m; // RULE23
         io_discharge <= lnk.discharge_on; // RULE1
         horn_metal_drive <= horn_on;
         // standby pulse per 32 s, faster in local, dark in remote
         led_on <= (standby || local_m) &&
            (phase_cnt < P_OSC_CYC); // RULE24
         emitter_drive <= norm_emit;
         amp_bias_on <= (smp_window && !horn_on) || chamber_win;
         high_gain_sel <= chamber_win; // RULE6
         hysteresis_en <= local_m;
         amp_to_high_gain_cap_pin <= 1'b0;
         amp_to_normal_gain_cap_pin <= 1'b0;
      end
   end

   // ==========================================================
   // apb slave, zero wait states
   assign apb_setup = psel && !penable;
   assign apb_access = psel && penable;
   assign addr_ok = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS);
   assign pready = 1'b1;
   assign pslverr = apb_access && !addr_ok;

   always_comb begin
      status_word = 32'h0;
      status_word[STAT_MODE_LSB +: 4] = mode;
      status_word[STAT_LOW_BATT_BIT] = low_batt;
      status_word[STAT_CHAMBER_BIT] = chamber_fault;
      status_word[STAT_REMOTE_BIT] = lnk.remote_level;
      status_word[STAT_DUMP_BIT] = lnk.discharge_on;
      status_word[STAT_HORN_BIT] = horn_on;
   end

   // read data captured in setup so it stands through access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (apb_setup && !pwrite) begin
         if (paddr == ADDR_CTRL) begin
            prdata <= 32'h0;
            prdata[CTRL_EXT_CLK_BIT] <= ext_clk_sel;
         end else if (paddr == ADDR_STATUS) begin
            prdata <= status_word;
         end else begin
            prdata <= 32'h0;
         end
      end
   end

   // control writes: clock source select and diagnostic exit pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_clk_sel <= CTRL_EXT_CLK_RESET;
         diag_exit <= 1'b0;
      end else if (apb_access && pwrite && paddr == ADDR_CTRL) begin
         ext_clk_sel <= pwdata[CTRL_EXT_CLK_BIT];
         diag_exit <= pwdata[CTRL_DIAG_EXIT_BIT];
      end else begin
         diag_exit <= 1'b0;
      end
   end

endmodule

/* dv/smoke_ctrl_sva.sv */
`timescale 1ns/1ns
module smoke_ctrl_sva #(parameter int unsigned P_DUMP_CYC = 12) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   // pins
   input wire logic io_out,
   input wire logic io_oe,
   input wire logic io_discharge,
   input wire logic horn_metal_drive,
   input wire logic led_on
);
   // ====
   // one domain, so clock and reset are given once
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   int dcnt;
   // length of the current dump, zero outside one
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn) dcnt <= 0;
      else dcnt <= io_discharge ? dcnt + 1 : 0;
   AST_IO_HIGH: assert property (io_oe |-> io_out)
      else $error("interconnect enabled but not high");
   AST_OE_HORN: assert property ($rose(io_oe) |->
      ##[0:3] horn_metal_drive) else $error("local alarm without horn");
   AST_DUMP_AFTER: assert property ($fell(io_oe) |->
      ##[0:2] io_discharge) else $error("no dump after local alarm");
   AST_DUMP_LEN: assert property ($fell(io_discharge) |->
      dcnt == P_DUMP_CYC) else $error("dump length wrong");
   AST_DUMP_SRC: assert property ($rose(io_discharge) |->
      $past(io_oe) || $past(io_oe, 2)) else $error("dump not after local");
   AST_DUMP_NO_OE: assert property (io_discharge |-> !io_oe)
      else $error("dump while driving");
   AST_LED_LEN: assert property ($rose(led_on) && !io_oe |->
      led_on[*8]) else $error("indicator pulse too short");
   AST_READY: assert property (pready) else $error("pready low");
   AST_SLVERR: assert property (psel && penable && paddr != 8'h00 &&
      paddr != 8'h04 |-> pslverr) else $error("no error on bad address");
   cover property (io_oe);
   cover property ($fell(io_discharge));
   cover property (pslverr);
endmodule
bind smoke_ctrl smoke_ctrl_sva #(.P_DUMP_CYC(P_DUMP_CYC)) smoke_ctrl_sva_inst (
   .pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr, .io_out,
   .io_oe, .io_discharge, .horn_metal_drive, .led_on);

/* dv/io_peer.sv */
`timescale 1ns/1ns
module io_peer (
   // clock and command
   input wire logic pclk,
   input wire logic alarm_req,
   // line drive
   output logic drive_high
);
   // ====
   // peer raises the line only while alarming; pull-down otherwise
   always_ff @(posedge pclk) drive_high <= alarm_req;
endmodule

/* dv/smoke_ctrl_tb_top.sv */
`timescale 1ns/1ns
`define CK(n,e,v) checks_done++; if ((v) !== (e)) begin errors++; \
   $display("unexpected %s exp %h got %h", n, e, v); end
module smoke_ctrl_tb_top;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, err, io_in, io_out, io_oe, io_discharge;
   logic smoke_detected = 0, low_batt_compare = 0, peer_req = 0;
   logic chamber_fail_compare = 0, test_diag_entry = 0, peer_hi;
   logic battery_threshold_ref = 0, feed_in = 0, osc_capacitor_pin = 0;
   logic horn_metal_drive, led_on, amp_bias_on;
   logic emitter_drive, high_gain_sel, hysteresis_en, to_norm_cap;
   int errors = 0, checks_done = 0, cyc = 0, n;
   // ====
   // horn period longer than the fast window so samples get through
   smoke_ctrl #(.P_OSC_CYC(10), .P_DIAG_OSC_CYC(13), .P_PERIOD_CYC(400),
      .P_SAMPLE_CYC(100), .P_FAST_CYC(30), .P_CHAMBER_OFS_CYC(200),
      .P_FILTER_CYC(6), .P_DUMP_CYC(12), .P_HORN_ON_CYC(25),
      .P_HORN_PERIOD_CYC(40), .P_LED_ALARM_CYC(20)) smoke_ctrl_inst (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .smoke_detected, .low_batt_compare,
      .chamber_fail_compare, .test_diag_entry, .battery_threshold_ref,
      .feed_in, .osc_capacitor_pin, .io_in, .io_out, .io_oe,
      .io_discharge, .horn_metal_drive, .led_on, .emitter_drive,
      .amp_bias_on, .high_gain_sel, .hysteresis_en,
      .amp_to_high_gain_cap_pin(), .amp_to_normal_gain_cap_pin(to_norm_cap));
   io_peer io_peer_inst (.pclk, .alarm_req(peer_req), .drive_high(peer_hi));
   // shared wire, pulled down when nobody drives it
   assign io_in = io_oe ? io_out : peer_hi;
   initial forever #50 pclk = ~pclk;
   // ====
   // one apb transfer; q and err hold the answer
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk) penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task tally_and_finish();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // hang guard above the run length
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1;
      apb(1, 8'h00, 32'h2);
      apb(0, 8'h00, 0);
      `CK("ctrl", 32'h2, q)
      apb(1, 8'h00, 32'h0);
      apb(0, 8'h08, 0);
      `CK("bad addr", 2'b10, {err, |q})
      // short peer pulse must be filtered out
      peer_req <= 1;
      repeat (4) @(posedge pclk);
      peer_req <= 0;
      apb(0, 8'h04, 0);
      `CK("mode", 4'h1, q[3:0])
      peer_req <= 1;
      repeat (20) @(negedge pclk);
      apb(0, 8'h04, 0);
      `CK("mode", 4'h4, q[3:0])
      repeat (50) if (!horn_metal_drive) @(negedge pclk);
      `CK("horn", 1'b1, horn_metal_drive)
      peer_req <= 0;
      repeat (10) @(negedge pclk);
      `CK("horn", 1'b0, horn_metal_drive)
      `CK("dump", 1'b0, io_discharge)
      apb(0, 8'h04, 0);
      `CK("mode", 4'h1, q[3:0])
      // local alarm from smoke, then dump on exit
      smoke_detected <= 1;
      repeat (2000) if (!io_oe) @(negedge pclk);
      `CK("io_oe", 2'b11, {io_oe, io_out})
      @(posedge pclk) smoke_detected <= 0;
      repeat (2000) if (io_oe) @(negedge pclk);
      repeat (2) @(negedge pclk);
      `CK("dump", 1'b1, io_discharge)
      // low battery chirp is one oscillator period
      @(posedge pclk) low_batt_compare <= 1;
      repeat (900) if (!horn_metal_drive) @(negedge pclk);
      for (n = 0; horn_metal_drive && n < 99; n++) @(negedge pclk);
      `CK("chirp", 10, n)
      apb(0, 8'h04, 0);
      `CK("low batt", 1'b1, q[4])
      low_batt_compare <= 0;
      chamber_fail_compare <= 1;
      repeat (900) @(negedge pclk);
      apb(0, 8'h04, 0);
      `CK("chamber", 1'b1, q[5])
      chamber_fail_compare <= 0;
      // diagnostic entry and redefined pins
      test_diag_entry <= 1;
      repeat (12) @(posedge pclk);
      test_diag_entry <= 0;
      apb(0, 8'h04, 0);
      `CK("mode", 4'h8, q[3:0])
      peer_req <= 1;
      smoke_detected <= 1;
      low_batt_compare <= 1;
      feed_in <= 1;
      repeat (12) @(negedge pclk);
      `CK("io_oe", 1'b0, io_oe)
      `CK("horn", 1'b1, horn_metal_drive)
      `CK("led", 1'b1, led_on)
      `CK("bias", 1'b1, amp_bias_on)
      `CK("gain", 2'b01, {high_gain_sel, hysteresis_en})
      @(posedge pclk) battery_threshold_ref <= 1;
      repeat (2) @(negedge pclk);
      `CK("gain", 3'h5, {high_gain_sel, hysteresis_en, to_norm_cap})
      `CK("emit", 1'b1, emitter_drive)
      apb(1, 8'h00, 32'h1);
      apb(0, 8'h04, 0);
      `CK("mode", 4'h1, q[3:0])
      tally_and_finish();
   end
endmodule
